// >>> rtl/dlc_pkg.sv
// Purpose: shared constants for the dual-channel antenna supply control register bank
// Assumes: 8-bit system registers, 3-bit selector in the top bits of every data byte
// Notes: field positions are bit indices inside one register byte
package dlc_pkg;
  typedef logic [7:0] dlc_byte_t;
  typedef logic [2:0] dlc_sel_t;

  // Register selector codes
  localparam dlc_sel_t DLC_SEL_CH1_STATUS = 3'h0;
  localparam dlc_sel_t DLC_SEL_CH1_TONE = 3'h1;
  localparam dlc_sel_t DLC_SEL_CH1_CMD = 3'h2;
  localparam dlc_sel_t DLC_SEL_CH1_CTRL = 3'h3;
  localparam dlc_sel_t DLC_SEL_CH2_STATUS = 3'h4;
  localparam dlc_sel_t DLC_SEL_CH2_TONE = 3'h5;
  localparam dlc_sel_t DLC_SEL_CH2_CMD = 3'h6;
  localparam dlc_sel_t DLC_SEL_CH2_CTRL = 3'h7;
  localparam int DLC_NUM_REGS = 8;
  localparam dlc_byte_t DLC_REG_RESET = 8'h00;

  // Selector field and status fields
  localparam int DLC_SEL_MSB = 7;
  localparam int DLC_SEL_LSB = 5;
  localparam int DLC_ST_OVERHEAT = 4;
  localparam int DLC_ST_CABLE = 3;
  localparam int DLC_ST_VOLTAGE = 2;
  localparam int DLC_ST_OVERLOAD = 1;
  localparam int DLC_ST_REVERSE = 0;
  localparam int DLC_FLAG_W = 4;
  // Tone register fields
  localparam int DLC_TN_GATE = 4;
  localparam int DLC_TN_MODSRC = 3;
  localparam int DLC_TN_LEVEL = 2;
  // Command register fields
  localparam int DLC_CM_STATIC = 4;
  localparam int DLC_CM_PINMASK = 3;
  localparam int DLC_CM_RANGE = 2;
  localparam int DLC_CM_HIGH = 1;
  localparam int DLC_CM_LOW = 0;
  // Control register fields
  localparam int DLC_CT_POWER = 4;
  localparam int DLC_CT_UPPER = 1;
  localparam int DLC_CT_LOWER = 0;

  // Slave address: fixed upper five bits, straps give the low two
  localparam logic [4:0] DLC_ADDR_PREFIX = 5'h02;
  localparam logic [3:0] DLC_BITS_PER_BYTE = 4'h8;

  // Current limit codes: 275, 350, 515, 635, 800 mA
  typedef enum logic [2:0] {
    DLC_LIM_275 = 3'b000,
    DLC_LIM_350 = 3'b100,
    DLC_LIM_515 = 3'b101,
    DLC_LIM_635 = 3'b110,
    DLC_LIM_800 = 3'b111
  } dlc_limit_t;

  // Output voltage codes: 13, 14, 18, 19 V
  typedef enum logic [1:0] {
    DLC_V13 = 2'b00,
    DLC_V14 = 2'b01,
    DLC_V18 = 2'b10,
    DLC_V19 = 2'b11
  } dlc_volt_t;

  typedef enum logic [2:0] {
    DLC_IDLE = 3'b000,
    DLC_ADDR = 3'b001,
    DLC_ADDR_ACK = 3'b010,
    DLC_WRITE = 3'b011,
    DLC_WRITE_ACK = 3'b100,
    DLC_READ = 3'b101,
    DLC_READ_ACK = 3'b110
  } dlc_state_t;
endpackage

// >>> rtl/dlc_channel.sv
// Purpose: one output channel's decode of tone, limit and voltage settings and its status flags
// Assumes: analog comparators deliver levels synchronous to the core clock
// Notes: instantiated once per channel by the register bank
`timescale 1ns/1ps
`default_nettype none
module dlc_channel
  import dlc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clear,
  input wire dlc_pkg::dlc_byte_t i_tone_reg,
  input wire dlc_pkg::dlc_byte_t i_cmd_reg,
  input wire dlc_pkg::dlc_byte_t i_ctrl_reg,
  input wire logic i_overheat,
  input wire logic i_range_select_pin,
  input wire logic i_external_modulation_input,
  input wire logic i_tone_osc,
  input wire logic i_over_limit,
  input wire logic i_reverse_over_limit,
  input wire logic i_voltage_out_of_range,
  input wire logic i_load_below_low,
  input wire logic i_load_above_connected,
  output logic o_channel_power_on,
  output logic o_tone_out,
  output logic o_tone_detect_level,
  output logic o_static_limit_choice,
  output dlc_pkg::dlc_limit_t o_limit_code,
  output dlc_pkg::dlc_volt_t o_voltage_code,
  output logic [DLC_FLAG_W-1:0] o_flags
);
  import dlc_pkg::*;

  logic power_on;
  logic cable_open_flag;
  logic next_tone;
  dlc_limit_t next_limit;
  dlc_volt_t next_volt;

  // Overheat shuts down boost and linear stage together
  assign power_on = i_ctrl_reg[DLC_CT_POWER] & ~i_overheat;

  always_comb
  begin
    if (i_tone_reg[DLC_TN_MODSRC])
      next_tone = i_external_modulation_input;
    else if (i_tone_reg[DLC_TN_GATE])
      next_tone = i_tone_osc;
    else
      next_tone = i_tone_osc & i_external_modulation_input;
  end

  always_comb
  begin
    if (!i_cmd_reg[DLC_CM_RANGE])
      next_limit = DLC_LIM_275;
    else
    begin
      case ({i_cmd_reg[DLC_CM_HIGH], i_cmd_reg[DLC_CM_LOW]})
        2'b00: next_limit = DLC_LIM_350;
        2'b01: next_limit = DLC_LIM_515;
        2'b10: next_limit = DLC_LIM_635;
        2'b11: next_limit = DLC_LIM_800;
        default: next_limit = DLC_LIM_275;
      endcase
    end
  end

  always_comb
  begin
    if (i_cmd_reg[DLC_CM_PINMASK])
      next_volt = dlc_volt_t'({i_ctrl_reg[DLC_CT_UPPER], i_ctrl_reg[DLC_CT_LOWER]});
    else if (i_range_select_pin)
      next_volt = i_ctrl_reg[DLC_CT_UPPER] ? DLC_V19 : DLC_V18;
    else
      next_volt = i_ctrl_reg[DLC_CT_LOWER] ? DLC_V14 : DLC_V13;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || i_clear)
    begin
      o_channel_power_on <= 1'b0;
      o_tone_out <= 1'b0;
      o_tone_detect_level <= 1'b0;
      o_static_limit_choice <= 1'b0;
      o_limit_code <= DLC_LIM_275;
      o_voltage_code <= DLC_V13;
    end
    else
    begin
      o_channel_power_on <= power_on;
      o_tone_out <= next_tone & power_on;
      o_tone_detect_level <= i_tone_reg[DLC_TN_LEVEL];
      o_static_limit_choice <= i_cmd_reg[DLC_CM_STATIC];
      o_limit_code <= next_limit;
      o_voltage_code <= next_volt;
    end
  end

  // Cable flag keeps its value between the two thresholds
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || i_clear)
      cable_open_flag <= 1'b0;
    else if (i_load_below_low)
      cable_open_flag <= 1'b1;
    else if (i_load_above_connected)
      cable_open_flag <= 1'b0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || i_clear)
      o_flags <= '0;
    else
    begin
      o_flags[DLC_ST_CABLE] <= cable_open_flag;
      o_flags[DLC_ST_VOLTAGE] <= i_voltage_out_of_range;
      o_flags[DLC_ST_OVERLOAD] <= i_over_limit;
      o_flags[DLC_ST_REVERSE] <= i_reverse_over_limit & (~i_cmd_reg[DLC_CM_STATIC] | ~power_on);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dlc_register_bank.sv
// Purpose: eight system registers of a dual antenna supply controller behind a serial slave port
// Assumes: serial clock and data are sampled on the 10 MHz core clock as synchronous inputs
// Notes: power-good low acts as a reset of registers and serial port alike
// Operation
// - All eight registers clear to zero at power up, both channels off.
// - Top three bits of each written byte choose one of eight registers.
// - Register writes are taken only when the address direction bit is zero.
// - Status low five bits are read-only; only selector bits are writable.
// - Overload flag follows output current exceeding the programmed limit.
// - Reverse flag set on reverse overcurrent in dynamic limiting or shutdown.
// - Voltage fault flag follows input or output voltage out of range.
// - Cable flag sets below low threshold, clears above connected threshold.
// - Shared overheat flag sets above upper threshold, clears at lower; powers off.
// - Tone enable and source both zero: internal tone gated by modulation pin.
// - Tone enable zero, source one: modulation pin passed straight to output.
// - Tone enable one, source zero: internal tone gated by enable bit.
// - Tone level bit picks receive or transmit detector threshold.
// - Range and code bits pick 275, 350, 515, 635 or 800 mA.
// - Limit mode bit zero selects dynamic, one selects static limiting.
// - Pin mask bit zero honours the range pin, one ignores it.
// - With pin ignored, upper and lower bits pick 13, 14, 18 or 19 V.
// - Pin honoured and high: 18 V or 19 V from the upper bit.
// - Pin honoured and low: 13 V or 14 V from the lower bit.
// - Clearing channel enable turns off its boost and linear stages.
// - Channel 2 uses codes four to seven, same layout, status bit 4 unused.
// - Unused bits are don't-care on writes and may be reused.
// - Reads return bytes MSB first, continuing while the master acknowledges.
// - Slave address is fixed upper five bits plus two strap pins.
// - While power-good is low, port ignores commands and registers stay zero.
// - Fault output low on overheat, overload, reverse fault or both channels off.
`timescale 1ns/1ps
`default_nettype none
module dlc_register_bank
  import dlc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_power_good,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_slave_id_strap_lo,
  input wire logic i_slave_id_strap_hi,
  input wire logic i_temp_above_upper,
  input wire logic i_temp_at_lower,
  input wire logic i_tone_osc,
  input wire logic i_ch1_range_select_pin,
  input wire logic i_ch1_external_modulation_input,
  input wire logic i_ch1_over_limit,
  input wire logic i_ch1_reverse_over_limit,
  input wire logic i_ch1_voltage_out_of_range,
  input wire logic i_ch1_load_below_low,
  input wire logic i_ch1_load_above_connected,
  input wire logic i_ch2_range_select_pin,
  input wire logic i_ch2_external_modulation_input,
  input wire logic i_ch2_over_limit,
  input wire logic i_ch2_reverse_over_limit,
  input wire logic i_ch2_voltage_out_of_range,
  input wire logic i_ch2_load_below_low,
  input wire logic i_ch2_load_above_connected,
  output logic o_ch1_channel_power_on,
  output logic o_ch1_tone_out,
  output logic o_ch1_tone_detect_level,
  output logic o_ch1_static_limit_choice,
  output dlc_pkg::dlc_limit_t o_ch1_limit_code,
  output dlc_pkg::dlc_volt_t o_ch1_voltage_code,
  output logic o_ch2_channel_power_on,
  output logic o_ch2_tone_out,
  output logic o_ch2_tone_detect_level,
  output logic o_ch2_static_limit_choice,
  output dlc_pkg::dlc_limit_t o_ch2_limit_code,
  output dlc_pkg::dlc_volt_t o_ch2_voltage_code,
  output logic o_overheat_flag,
  output logic o_fault_out_n
);
  import dlc_pkg::*;

  dlc_byte_t regs [DLC_NUM_REGS];
  dlc_state_t state;
  logic clear;
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [3:0] bit_cnt;
  dlc_byte_t rx_shift;
  dlc_byte_t tx_shift;
  logic read_mode;
  logic master_ack;
  dlc_sel_t read_ptr;
  logic addr_match;
  logic write_strobe;
  logic load_byte;
  dlc_byte_t read_byte;
  logic [DLC_FLAG_W-1:0] ch1_flags;
  logic [DLC_FLAG_W-1:0] ch2_flags;
  logic ch1_power;
  logic ch2_power;

  // Power-good low holds everything at reset values
  assign clear = ~i_power_good;

  // Open-drain data line: only ever pulled low
  assign o_sda_out = 1'b0;

  assign scl_rise = i_scl & ~scl_prev;
  assign scl_fall = ~i_scl & scl_prev;
  assign start_seen = i_scl & scl_prev & sda_prev & ~i_sda;
  assign stop_seen = i_scl & scl_prev & ~sda_prev & i_sda;

  // Straps are read live, so a re-strap takes effect on the next address byte
  assign addr_match = (rx_shift[7:1] == {DLC_ADDR_PREFIX, i_slave_id_strap_hi, i_slave_id_strap_lo});

  assign write_strobe = (state == DLC_WRITE) && scl_fall && (bit_cnt == DLC_BITS_PER_BYTE);
  assign load_byte = scl_fall &&
    (((state == DLC_ADDR_ACK) && read_mode) || ((state == DLC_READ_ACK) && master_ack));

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || clear)
      {scl_prev, sda_prev} <= 2'b11;
    else
      {scl_prev, sda_prev} <= {i_scl, i_sda};
  end

  // Status registers return live flags under the stored selector bits
  always_comb
  begin
    read_byte = regs[read_ptr];
    case (read_ptr)
      DLC_SEL_CH1_STATUS:
        read_byte = {regs[read_ptr][DLC_SEL_MSB:DLC_SEL_LSB], o_overheat_flag, ch1_flags};
      DLC_SEL_CH2_STATUS:
        read_byte = {regs[read_ptr][DLC_SEL_MSB:DLC_SEL_LSB], 1'b0, ch2_flags};
      default:
        read_byte = regs[read_ptr];
    endcase
  end

  // Serial port sequencer
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || clear)
    begin
      state <= DLC_IDLE;
      o_sda_oe <= 1'b0;
      bit_cnt <= '0;
    end
    else if (start_seen || stop_seen)
    begin
      state <= start_seen ? DLC_ADDR : DLC_IDLE;
      o_sda_oe <= 1'b0;
      bit_cnt <= '0;
    end
    else
    begin
      // Idle shares the default branch: line stays released
      case (state)
        DLC_ADDR, DLC_WRITE:
        begin
          if (scl_rise && bit_cnt != DLC_BITS_PER_BYTE)
            bit_cnt <= bit_cnt + 4'h1;
          else if (scl_fall && bit_cnt == DLC_BITS_PER_BYTE)
          begin
            if (state == DLC_WRITE)
            begin
              state <= DLC_WRITE_ACK;
              o_sda_oe <= 1'b1;
            end
            else if (addr_match)
            begin
              state <= DLC_ADDR_ACK;
              o_sda_oe <= 1'b1;
            end
            else
              state <= DLC_IDLE;
          end
        end
        DLC_ADDR_ACK, DLC_WRITE_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= '0;
            if (load_byte)
            begin
              state <= DLC_READ;
              o_sda_oe <= ~read_byte[7];
              bit_cnt <= 4'h1;
            end
            else
            begin
              state <= DLC_WRITE;
              o_sda_oe <= 1'b0;
            end
          end
        end
        DLC_READ:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == DLC_BITS_PER_BYTE)
            begin
              state <= DLC_READ_ACK;
              o_sda_oe <= 1'b0;
            end
            else
            begin
              o_sda_oe <= ~tx_shift[7];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        DLC_READ_ACK:
        begin
          if (scl_rise && i_sda)
            state <= DLC_IDLE;
          else if (load_byte)
          begin
            state <= DLC_READ;
            o_sda_oe <= ~read_byte[7];
            bit_cnt <= 4'h1;
          end
        end
        default:
        begin
          state <= DLC_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Receive shifter, direction bit and master acknowledge capture
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || clear)
    begin
      rx_shift <= DLC_REG_RESET;
      read_mode <= 1'b0;
      master_ack <= 1'b0;
    end
    else
    begin
      if (scl_rise && (state == DLC_ADDR || state == DLC_WRITE) && bit_cnt != DLC_BITS_PER_BYTE)
        rx_shift <= {rx_shift[6:0], i_sda};
      if (state == DLC_ADDR && scl_fall && bit_cnt == DLC_BITS_PER_BYTE)
        read_mode <= rx_shift[0];
      if (state == DLC_READ_ACK && scl_rise)
        master_ack <= ~i_sda;
      else if (state != DLC_READ_ACK)
        master_ack <= 1'b0;
    end
  end

  // Transmit shifter; read pointer restarts at the first register per read transfer
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || clear || state == DLC_ADDR)
      read_ptr <= DLC_SEL_CH1_STATUS;
    else if (load_byte)
    begin
      tx_shift <= {read_byte[6:0], 1'b0};
      read_ptr <= read_ptr + 3'h1;
    end
    else if (state == DLC_READ && scl_fall && bit_cnt != DLC_BITS_PER_BYTE)
      tx_shift <= {tx_shift[6:0], 1'b0};
  end

  // Register file: selector in the top bits picks the target
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || clear)
      for (int i = 0; i < DLC_NUM_REGS; i++)
        regs[i] <= DLC_REG_RESET;
    else if (write_strobe)
    begin
      case (rx_shift[DLC_SEL_MSB:DLC_SEL_LSB])
        DLC_SEL_CH1_STATUS, DLC_SEL_CH2_STATUS:
          regs[rx_shift[DLC_SEL_MSB:DLC_SEL_LSB]] <= {rx_shift[DLC_SEL_MSB:DLC_SEL_LSB], 5'h00};
        default:
          regs[rx_shift[DLC_SEL_MSB:DLC_SEL_LSB]] <= rx_shift;
      endcase
    end
  end

  // Shared overheat flag with hysteresis between the two thresholds
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || clear)
      o_overheat_flag <= 1'b0;
    else if (i_temp_above_upper)
      o_overheat_flag <= 1'b1;
    else if (i_temp_at_lower)
      o_overheat_flag <= 1'b0;
  end

  assign ch1_power = regs[DLC_SEL_CH1_CTRL][DLC_CT_POWER];
  assign ch2_power = regs[DLC_SEL_CH2_CTRL][DLC_CT_POWER];

  // Both channels off also raises the fault so the host notices a lost setup
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || clear)
      o_fault_out_n <= 1'b0;
    else
      o_fault_out_n <= ~(o_overheat_flag |
        ch1_flags[DLC_ST_OVERLOAD] | ch1_flags[DLC_ST_REVERSE] |
        ch2_flags[DLC_ST_OVERLOAD] | ch2_flags[DLC_ST_REVERSE] |
        (~ch1_power & ~ch2_power));
  end

  dlc_channel u_ch1 (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clear(clear),
    .i_tone_reg(regs[DLC_SEL_CH1_TONE]),
    .i_cmd_reg(regs[DLC_SEL_CH1_CMD]),
    .i_ctrl_reg(regs[DLC_SEL_CH1_CTRL]),
    .i_overheat(o_overheat_flag),
    .i_range_select_pin(i_ch1_range_select_pin),
    .i_external_modulation_input(i_ch1_external_modulation_input),
    .i_tone_osc(i_tone_osc),
    .i_over_limit(i_ch1_over_limit),
    .i_reverse_over_limit(i_ch1_reverse_over_limit),
    .i_voltage_out_of_range(i_ch1_voltage_out_of_range),
    .i_load_below_low(i_ch1_load_below_low),
    .i_load_above_connected(i_ch1_load_above_connected),
    .o_channel_power_on(o_ch1_channel_power_on),
    .o_tone_out(o_ch1_tone_out),
    .o_tone_detect_level(o_ch1_tone_detect_level),
    .o_static_limit_choice(o_ch1_static_limit_choice),
    .o_limit_code(o_ch1_limit_code),
    .o_voltage_code(o_ch1_voltage_code),
    .o_flags(ch1_flags)
  );

  // Second channel: same layout at selector codes four to seven
  dlc_channel u_ch2 (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clear(clear),
    .i_tone_reg(regs[DLC_SEL_CH2_TONE]),
    .i_cmd_reg(regs[DLC_SEL_CH2_CMD]),
    .i_ctrl_reg(regs[DLC_SEL_CH2_CTRL]),
    .i_overheat(o_overheat_flag),
    .i_range_select_pin(i_ch2_range_select_pin),
    .i_external_modulation_input(i_ch2_external_modulation_input),
    .i_tone_osc(i_tone_osc),
    .i_over_limit(i_ch2_over_limit),
    .i_reverse_over_limit(i_ch2_reverse_over_limit),
    .i_voltage_out_of_range(i_ch2_voltage_out_of_range),
    .i_load_below_low(i_ch2_load_below_low),
    .i_load_above_connected(i_ch2_load_above_connected),
    .o_channel_power_on(o_ch2_channel_power_on),
    .o_tone_out(o_ch2_tone_out),
    .o_tone_detect_level(o_ch2_tone_detect_level),
    .o_static_limit_choice(o_ch2_static_limit_choice),
    .o_limit_code(o_ch2_limit_code),
    .o_voltage_code(o_ch2_voltage_code),
    .o_flags(ch2_flags)
  );
endmodule
`default_nettype wire

// >>> sim/dlc_master.sv
// Purpose: serial bus master model of the host for the register bank
// Assumes: open-drain data line with pull-up, resolved in the bench
// Notes: phase sets the clock low time in core cycles
`timescale 1ns/1ps
`default_nettype none
module dlc_master
(
  input wire logic i_core_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  import dlc_pkg::*;
  int phase = 4;
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic start;
    o_sda = 1'b0;
    wait_n(4);
    o_scl = 1'b0;
  endtask
  task automatic stop;
    o_sda = 1'b0;
    wait_n(4);
    o_scl = 1'b1;
    wait_n(4);
    o_sda = 1'b1;
    wait_n(4);
  endtask
  // Data only moves while the clock is low
  task automatic clk_bit(input logic b, output logic r);
    o_sda = b;
    wait_n(phase);
    o_scl = 1'b1;
    wait_n(2);
    r = i_sda;
    wait_n(phase - 2);
    o_scl = 1'b0;
  endtask
  // Sending 1 releases the line, so reads and acks share this path
  task automatic xfer(input dlc_byte_t d, input logic ack_in, output dlc_byte_t q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(d[i], r);
      q[i] = r;
    end
    clk_bit(ack_in, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// >>> sim/dlc_register_bank_assertions.sv
// Purpose: port-level checks of the register bank
// Assumes: one core clock domain
// Notes: attached by bind
`timescale 1ns/1ps
`default_nettype none
module dlc_register_bank_assertions
  import dlc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_power_good,
  input wire logic i_scl,
  input wire logic i_temp_above_upper,
  input wire logic i_temp_at_lower,
  input wire logic i_ch1_over_limit,
  input wire logic o_sda_oe,
  input wire logic o_ch1_channel_power_on,
  input wire dlc_pkg::dlc_limit_t o_ch1_limit_code,
  input wire dlc_pkg::dlc_volt_t o_ch1_voltage_code,
  input wire logic o_overheat_flag,
  input wire logic o_fault_out_n
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  reset_clear_a: assert property ($fell(i_reset) |-> !o_ch1_channel_power_on && !o_fault_out_n
    && o_ch1_limit_code == DLC_LIM_275 && o_ch1_voltage_code == DLC_V13) else $error("outputs not clear");
  heat_set_a: assert property (i_power_good && i_temp_above_upper ##1 i_power_good |-> o_overheat_flag)
    else $error("overheat not set");
  heat_clear_a: assert property (!i_temp_above_upper && i_temp_at_lower |=> !o_overheat_flag)
    else $error("overheat not cleared");
  heat_hold_a: assert property (i_power_good && !i_temp_above_upper && !i_temp_at_lower
    ##1 i_power_good |-> $stable(o_overheat_flag)) else $error("overheat not held");
  heat_off_a: assert property (o_overheat_flag && i_temp_above_upper
    |=> !o_ch1_channel_power_on && !o_fault_out_n) else $error("power not cut");
  overload_fault_a: assert property (i_ch1_over_limit [*2] |=> !o_fault_out_n)
    else $error("no fault on overload");
  power_quiet_a: assert property (!i_power_good |=> !o_sda_oe) else $error("answer without power");
  ack_low_a: assert property ($rose(o_sda_oe) |-> !i_scl) else $error("drive with clock high");
  drive_hold_a: assert property (i_power_good && i_scl && $past(i_scl) && $past(i_scl, 2)
    && !$past(i_reset) |-> $stable(o_sda_oe)) else $error("data moved with clock high");
endmodule
bind dlc_register_bank dlc_register_bank_assertions u_chk (.i_core_clk, .i_reset, .i_power_good, .i_scl,
  .i_temp_above_upper, .i_temp_at_lower, .i_ch1_over_limit, .o_sda_oe, .o_ch1_channel_power_on,
  .o_ch1_limit_code, .o_ch1_voltage_code, .o_overheat_flag, .o_fault_out_n);
`default_nettype wire

// >>> sim/dlc_register_bank_tb.sv
// Purpose: self-checking bench for the antenna supply register bank
// Assumes: one write transfer carries two data bytes
// Notes: each scenario is its own task
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, s); end end
module dlc_register_bank_tb;
  import dlc_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic pg = 1'b1;
  logic upper = 1'b0;
  logic lower = 1'b0;
  logic osc = 1'b0;
  logic [1:0] strap = 2'b10;
  logic [1:0] sid = 2'b10;
  logic [6:0] c1 = '0;
  logic [6:0] c2 = '0;
  logic scl, msda, sda_oe, oh, fault_n, ok;
  logic p1, p2, t1, t2, dl1, dl2, sc1, sc2;
  dlc_limit_t l1, l2;
  dlc_volt_t v1, v2;
  dlc_byte_t q;
  int fails = 0;
  int checked = 0;
  wire logic sda = msda & ~sda_oe;
  always #50 i_core_clk = ~i_core_clk;
  dlc_master u_master (.i_core_clk(i_core_clk), .i_sda(sda), .o_scl(scl), .o_sda(msda));
  dlc_register_bank u_dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_power_good(pg), .i_scl(scl),
    .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe), .i_slave_id_strap_lo(strap[0]),
    .i_slave_id_strap_hi(strap[1]), .i_temp_above_upper(upper), .i_temp_at_lower(lower), .i_tone_osc(osc),
    .i_ch1_range_select_pin(c1[0]), .i_ch1_external_modulation_input(c1[1]), .i_ch1_over_limit(c1[2]),
    .i_ch1_reverse_over_limit(c1[3]), .i_ch1_voltage_out_of_range(c1[4]), .i_ch1_load_below_low(c1[5]),
    .i_ch1_load_above_connected(c1[6]), .i_ch2_range_select_pin(c2[0]),
    .i_ch2_external_modulation_input(c2[1]), .i_ch2_over_limit(c2[2]), .i_ch2_reverse_over_limit(c2[3]),
    .i_ch2_voltage_out_of_range(c2[4]), .i_ch2_load_below_low(c2[5]), .i_ch2_load_above_connected(c2[6]),
    .o_ch1_channel_power_on(p1), .o_ch1_tone_out(t1), .o_ch1_tone_detect_level(dl1),
    .o_ch1_static_limit_choice(sc1), .o_ch1_limit_code(l1), .o_ch1_voltage_code(v1),
    .o_ch2_channel_power_on(p2), .o_ch2_tone_out(t2), .o_ch2_tone_detect_level(dl2),
    .o_ch2_static_limit_choice(sc2), .o_ch2_limit_code(l2), .o_ch2_voltage_code(v2),
    .o_overheat_flag(oh), .o_fault_out_n(fault_n));
  task automatic wr(input dlc_byte_t a, input dlc_byte_t b);
    logic k;
    u_master.start();
    u_master.xfer({DLC_ADDR_PREFIX, sid, 1'b0}, 1'b1, q, ok);
    u_master.xfer(a, 1'b1, q, k);
    u_master.xfer(b, 1'b1, q, k);
    u_master.stop();
  endtask
  task automatic rd(input dlc_byte_t e [8]);
    logic k;
    u_master.start();
    u_master.xfer({DLC_ADDR_PREFIX, sid, 1'b1}, 1'b1, q, k);
    `CHK("read ack", 1'b1, k)
    for (int i = 0; i < 8; i++)
    begin
      u_master.xfer(8'hFF, i == 7, q, k);
      `CHK("read byte", e[i], q)
    end
    u_master.stop();
  endtask
  task automatic t_reset;
    `CHK("fault after reset", 1'b0, fault_n)
    `CHK("limit after reset", DLC_LIM_275, l1)
    `CHK("voltage after reset", DLC_V13, v1)
    `CHK("power after reset", 1'b0, p1 | p2)
  endtask
  task automatic t_addr;
    strap = 2'b01;
    wr(8'h70, 8'h70);
    `CHK("ack other id", 1'b0, ok)
    `CHK("power other id", 1'b0, p1)
    sid = 2'b01;
    c1 = 7'h02;
    wr(8'h70, 8'h2C);
    `CHK("ack own id", 1'b1, ok)
    `CHK("power own id", 1'b1, p1)
    `CHK("tone 1", 2'b11, {t1, dl1})
    `CHK("one channel on", 1'b1, fault_n)
    strap = 2'b10;
    sid = 2'b10;
  endtask
  task automatic t_limit;
    dlc_byte_t cm [7] = '{8'h00, 8'h13, 8'h04, 8'h05, 8'h06, 8'h17, 8'h07};
    dlc_limit_t ex [7] = '{DLC_LIM_275, DLC_LIM_275, DLC_LIM_350, DLC_LIM_515, DLC_LIM_635, DLC_LIM_275,
      DLC_LIM_800};
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h40 | cm[i], 8'hC0 | cm[i]);
      `CHK("static choice", {2{cm[i][4]}}, {sc1, sc2})
      // Limit code is only checked in dynamic mode
      if (!cm[i][4])
        `CHK("limit code", {ex[i], ex[i]}, {l1, l2})
    end
  endtask
  task automatic t_volt;
    dlc_volt_t ev;
    for (int i = 0; i < 16; i++)
    begin
      c1[0] = i[2];
      ev = dlc_volt_t'(i[3] ? i[1:0] : {i[2], i[2] ? i[1] : i[0]});
      wr({4'h4, i[3], 3'h0}, {6'b011100, i[1:0]});
      `CHK("voltage code", ev, v1)
    end
    wr(8'h60, 8'h60);
    `CHK("power off", 1'b0, p1)
    `CHK("both off fault", 1'b0, fault_n)
  endtask
  task automatic t_tone;
    for (int i = 0; i < 16; i++)
    begin
      osc = i[1];
      c2[1] = i[0];
      wr(8'hF3, {3'h5, i[3], i[2], i[0], 2'b00});
      `CHK("tone out", i[2] ? i[0] : i[1] & (i[3] | i[0]), t2)
      `CHK("detect level", i[0], dl2)
      `CHK("voltage 2", DLC_V14, v2)
    end
  endtask
  task automatic t_read;
    c1 = 7'h3C;
    c2 = 7'h20;
    wr(8'h1F, 8'h9F);
    rd('{8'h0F, 8'h2C, 8'h48, 8'h60, 8'h88, 8'hBC, 8'hC7, 8'hF3});
    `CHK("overload fault", 1'b0, fault_n)
  endtask
  task automatic t_heat;
    c1 = '0;
    upper = 1'b1;
    u_master.wait_n(4);
    `CHK("overheat set", 1'b1, oh)
    `CHK("power cut", 1'b0, p2)
    upper = 1'b0;
    u_master.wait_n(4);
    `CHK("overheat held", 1'b1, oh)
    lower = 1'b1;
    u_master.wait_n(4);
    `CHK("overheat clear", 1'b0, oh)
    `CHK("power back", 1'b1, p2)
    `CHK("no fault", 1'b1, fault_n)
    lower = 1'b0;
  endtask
  task automatic t_pg;
    pg = 1'b0;
    wr(8'hF0, 8'hF0);
    `CHK("ack without power", 1'b0, ok)
    `CHK("power held off", 1'b0, p2)
    pg = 1'b1;
    u_master.wait_n(2);
    // Slow host clock
    u_master.phase = 7;
    wr(8'hF0, 8'hF0);
    `CHK("ack after power", 1'b1, ok)
    `CHK("power after restore", 1'b1, p2)
  endtask
  task automatic conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge i_core_clk);
    #1;
    i_reset = 1'b0;
    u_master.wait_n(2);
    t_reset();
    t_addr();
    t_limit();
    t_volt();
    t_tone();
    t_read();
    t_heat();
    t_pg();
    conclude();
  end
  // Run needs about 1.1 ms
  initial
  begin
    #5000000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
